//--- hw/dual_data_pointer_unit.sv
// dual data pointer unit with an axi4-lite register slave
//
// Function
// RL1 - two independent 24-bit pointers; select 0 shows the main pointer bytes.
// RL2 - select 1 shows the shadow pointer bytes instead of the main one.
// RL3 - swap enable bit 6 toggles the active pointer after each pointer move; a control write in the same cycle overrides the swap.
// RL4 - bits 5:4 set shadow mode: none, increment, decrement, flip lsb.
// RL5 - bits 3:2 set main mode with the same four encodings.
// RL6 - flip-lsb mode inverts bit 0 only, other bits unchanged.
// RL7 - only moves addressing through the pointer trigger increment or decrement.
// RL8 - pc-relative and indirect byte register moves leave both pointers alone.
// RL9 - pointer byte accesses act on whichever pointer is active.
// RL10 - control bits 7 and 1 are not stored; writes to them ignored.
// RL11 - adjust the pointer active during the move first, then swap.
// RL12 - an automatic swap inverts the select bit, visible on readback.
`timescale 1ns/1ps

module dual_data_pointer_unit (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write address
  input  wire logic [active_address_pointer_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  // axi4-lite write data
  input  wire logic [active_address_pointer_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // axi4-lite write response
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // axi4-lite read address
  input  wire logic [active_address_pointer_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  // axi4-lite read data
  output logic [active_address_pointer_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // core side
  input  wire active_address_pointer_pkg::move_req_t         core_move,
  output logic [active_address_pointer_pkg::PTR_W-1:0]       active_address_pointer
);
  import active_address_pointer_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************

  // post-move adjustment of one pointer
  function automatic logic [PTR_W-1:0] adjust(input logic [PTR_W-1:0] ptr,
                                              input logic [1:0] mode);
    logic [PTR_W-1:0] res;
    res = ptr;
    case (mode)
      MODE_INC:      res = ptr + 24'h000001; // RL4 RL5
      MODE_DEC:      res = ptr - 24'h000001; // RL4 RL5
      MODE_FLIP_LSB: res = ptr ^ 24'h000001; // RL6
      default:       res = ptr;
    endcase
    return res;
  endfunction : adjust

  // byte address to register index, with a flag for a mapped register
  function automatic logic [8:0] decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic       hit;
    idx = addr[9:2];
    hit = (addr[11:10] == 2'h0) &&
          (idx == IDX_CONTROL || idx == IDX_LOW || idx == IDX_HIGH || idx == IDX_PAGE);
    return {hit, idx};
  endfunction : decode

  // ****************************************
  // state
  // ****************************************
  logic [7:0]        pointer_control;
  logic [PTR_W-1:0]  main_ptr;
  logic [PTR_W-1:0]  shadow_ptr;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane0_q;

  // ****************************************
  // write decode
  // ****************************************

  // a write is performed once address and data are both held
  wire              wr_fire   = !awready && !wready && !bvalid;
  wire [8:0]        wr_dec    = decode(aw_addr_q);
  wire              wr_hit    = wr_dec[8];
  wire [7:0]        wr_idx    = wr_dec[7:0];
  // registers are 8 bits wide, so only lane 0 carries a write
  wire              wr_go     = wr_fire && wr_hit && w_lane0_q;
  wire              ctrl_wr   = wr_go && (wr_idx == IDX_CONTROL);
  wire              low_wr    = wr_go && (wr_idx == IDX_LOW);
  wire              high_wr   = wr_go && (wr_idx == IDX_HIGH);
  wire              page_wr   = wr_go && (wr_idx == IDX_PAGE);
  wire              ptr_wr    = low_wr || high_wr || page_wr;

  // ****************************************
  // pointer datapath
  // ****************************************

  // only moves through the pointer itself step it
  wire ptr_move = core_move.valid &&
                  (core_move.kind == MOVE_ACTIVE_ADDRESS_POINTER_MOVX || core_move.kind == MOVE_ACTIVE_ADDRESS_POINTER_MOVC); // RL7 RL8

  wire              pointer_select   = pointer_control[SEL_BIT];
  wire              auto_swap_enable = pointer_control[SWAP_BIT];
  wire [1:0]        main_mode        = pointer_control[MAIN_MODE_LSB +: 2];
  wire [1:0]        shadow_mode      = pointer_control[SHADOW_MODE_LSB +: 2];

  // the pointer active during the move is the one adjusted
  wire [PTR_W-1:0]  cur_ptr     = pointer_select ? shadow_ptr : main_ptr; // RL1 RL2 RL9
  wire [1:0]        cur_mode    = pointer_select ? shadow_mode : main_mode; // RL4 RL5 RL11
  wire [PTR_W-1:0]  stepped_ptr = ptr_move ? adjust(cur_ptr, cur_mode) : cur_ptr;

  // a software byte write lands on top of a same-cycle step
  wire [PTR_W-1:0]  written_ptr = {page_wr ? w_data_q : stepped_ptr[23:16],
                                   high_wr ? w_data_q : stepped_ptr[15:8],
                                   low_wr  ? w_data_q : stepped_ptr[7:0]}; // RL9

  wire [PTR_W-1:0]  next_main   = pointer_select ? main_ptr : written_ptr;
  wire [PTR_W-1:0]  next_shadow = pointer_select ? written_ptr : shadow_ptr;

  // swap by flipping the select bit, after the adjustment above
  wire              swap_now    = ptr_move && auto_swap_enable; // RL3 RL11
  wire [7:0]        next_control = ctrl_wr ? (w_data_q & CTRL_MASK) // RL10
                                           : {pointer_control[7:1], pointer_select ^ swap_now}; // RL12
  wire [PTR_W-1:0]  next_active = next_control[SEL_BIT] ? next_shadow : next_main;

  // pointer registers and the registered view for the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pointer_control        <= CTRL_RESET;
      main_ptr               <= PTR_RESET;
      shadow_ptr             <= PTR_RESET;
      active_address_pointer <= PTR_RESET;
    end else begin
      pointer_control        <= next_control;
      main_ptr               <= next_main;
      shadow_ptr             <= next_shadow;
      active_address_pointer <= next_active; // RL1 RL2
    end
  end

  // ****************************************
  // axi4-lite write channels
  // ****************************************

  // address and data are taken independently and held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready    <= 1'b0;
        w_data_q  <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // axi4-lite read channels
  // ****************************************

  // read mux: pointer bytes come from the active pointer
  wire [8:0]        rd_dec  = decode(araddr);
  wire [7:0]        rd_byte = (rd_dec[7:0] == IDX_CONTROL) ? pointer_control :
                              (rd_dec[7:0] == IDX_LOW)     ? cur_ptr[7:0] :
                              (rd_dec[7:0] == IDX_HIGH)    ? cur_ptr[15:8] :
                              (rd_dec[7:0] == IDX_PAGE)    ? cur_ptr[23:16] : 8'h00; // RL9

  // one read at a time; data sampled in the cycle the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_dec[8] ? {24'h000000, rd_byte} : 32'h00000000;
        rresp   <= rd_dec[8] ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a pointer-addressed move with no software interference
  sequence seq_clean_move;
    ptr_move && !ptr_wr && !ctrl_wr;
  endsequence

  // a move that must not touch either pointer
  sequence seq_other_move;
    core_move.valid && !ptr_move && !ptr_wr;
  endsequence

  AST_MAIN_VISIBLE: assert property ( // RL1
    !pointer_select |-> active_address_pointer == main_ptr)
    else $error("main pointer not shown while selected");

  AST_SHADOW_VISIBLE: assert property ( // RL2
    pointer_select |-> active_address_pointer == shadow_ptr)
    else $error("shadow pointer not shown while selected");

  AST_SWAP_ON: assert property ( // RL3
    seq_clean_move ##0 auto_swap_enable |=> pointer_select != $past(pointer_select))
    else $error("active pointer not swapped after move");

  AST_SWAP_OFF: assert property ( // RL3
    seq_clean_move ##0 !auto_swap_enable |=> $stable(pointer_select))
    else $error("active pointer swapped with swap disabled");

  AST_SHADOW_INC: assert property ( // RL4
    seq_clean_move ##0 (pointer_select && shadow_mode == MODE_INC)
    |=> shadow_ptr == $past(shadow_ptr) + 24'h000001 && $stable(main_ptr))
    else $error("shadow pointer not incremented");

  AST_MAIN_DEC: assert property ( // RL5
    seq_clean_move ##0 (!pointer_select && main_mode == MODE_DEC)
    |=> main_ptr == $past(main_ptr) - 24'h000001 && $stable(shadow_ptr))
    else $error("main pointer not decremented");

  AST_FLIP_LSB: assert property ( // RL6
    seq_clean_move ##0 (!pointer_select && main_mode == MODE_FLIP_LSB)
    |=> main_ptr == {$past(main_ptr[23:1]), !$past(main_ptr[0])})
    else $error("flip mode changed more than bit 0");

  AST_OTHER_MOVES: assert property ( // RL8
    seq_other_move |=> $stable(main_ptr) && $stable(shadow_ptr))
    else $error("non-pointer move changed a pointer");

  AST_UNUSED_BITS: assert property ( // RL10
    pointer_control[7] == 1'b0 && pointer_control[1] == 1'b0)
    else $error("unimplemented control bits stored");

  AST_ADJUST_THEN_SWAP: assert property ( // RL11
    seq_clean_move ##0 (auto_swap_enable && !pointer_select && main_mode == MODE_INC)
    |=> pointer_select && main_ptr == $past(main_ptr) + 24'h000001
        && active_address_pointer == shadow_ptr)
    else $error("swap applied before adjusting the moved pointer");

  // the remaining mode codes on the other pointer, so each pointer sees every code
  AST_MAIN_INC: assert property ( // RL5
    seq_clean_move ##0 (!pointer_select && main_mode == MODE_INC)
    |=> main_ptr == $past(main_ptr) + 24'h000001 && $stable(shadow_ptr))
    else $error("main pointer not incremented");

  AST_SHADOW_DEC: assert property ( // RL4
    seq_clean_move ##0 (pointer_select && shadow_mode == MODE_DEC)
    |=> shadow_ptr == $past(shadow_ptr) - 24'h000001 && $stable(main_ptr))
    else $error("shadow pointer not decremented");

  AST_SHADOW_FLIP: assert property ( // RL6
    seq_clean_move ##0 (pointer_select && shadow_mode == MODE_FLIP_LSB)
    |=> shadow_ptr == {$past(shadow_ptr[23:1]), !$past(shadow_ptr[0])})
    else $error("shadow flip mode changed more than bit 0");

  AST_NO_MODE: assert property ( // RL4 RL5
    seq_clean_move ##0 (pointer_select ? shadow_mode == MODE_NONE : main_mode == MODE_NONE)
    |=> $stable(main_ptr) && $stable(shadow_ptr))
    else $error("pointer changed with its mode set to none");

  AST_WRITE_ACTIVE: assert property ( // RL9
    low_wr && !ptr_move |=> (pointer_select ? shadow_ptr[7:0] : main_ptr[7:0]) == $past(w_data_q))
    else $error("low byte write missed the active pointer");

  AST_WRITE_ANSWER: assert property (
    wr_fire |=> bvalid [*1] ##0 (bresp == $past(wr_hit ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response missing or wrong");

endmodule : dual_data_pointer_unit

//--- hw/active_address_pointer_pkg.sv
// constants, types and register map of the dual data pointer unit
package active_address_pointer_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PTR_W  = 24;

  // ****************************************
  // register indices (byte address is index times four)
  // ****************************************
  localparam logic [7:0] IDX_CONTROL = 8'hA7;
  localparam logic [7:0] IDX_LOW     = 8'hB0;
  localparam logic [7:0] IDX_HIGH    = 8'hB1;
  localparam logic [7:0] IDX_PAGE    = 8'hB2;

  // ****************************************
  // pointer_control fields
  // ****************************************
  localparam int unsigned SEL_BIT         = 0;
  localparam int unsigned MAIN_MODE_LSB   = 2;
  localparam int unsigned SHADOW_MODE_LSB = 4;
  localparam int unsigned SWAP_BIT        = 6;
  localparam logic [7:0]  CTRL_MASK       = 8'h7D;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [23:0] PTR_RESET       = 24'h000000;

  // ****************************************
  // bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // pointer modes and core move kinds
  // ****************************************
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_INC,
    MODE_DEC,
    MODE_FLIP_LSB
  } ptr_mode_t;

  typedef enum logic [1:0] {
    MOVE_ACTIVE_ADDRESS_POINTER_MOVX,
    MOVE_ACTIVE_ADDRESS_POINTER_MOVC,
    MOVE_PC_MOVC,
    MOVE_RI_MOVX
  } move_kind_t;

  // one move instruction retired by the core
  typedef struct packed {
    logic       valid;
    move_kind_t kind;
  } move_req_t;

endpackage : active_address_pointer_pkg

//--- verification/core_model.sv
// processor core model that retires moves of any kind toward the unit
`timescale 1ns/1ps
module core_model import active_address_pointer_pkg::*; (
  // clock
  input  wire logic          aclk,
  // retired moves
  output active_address_pointer_pkg::move_req_t core_move
);
  initial core_move = '0;
  // n moves back to back; valid drops right after the last one
  task automatic move(input move_kind_t kind, input int n);
    @(posedge aclk);
    core_move <= '{valid: 1'b1, kind: kind};
    repeat (n) @(posedge aclk);
    core_move <= '0;
  endtask : move
endmodule : core_model

//--- verification/dual_data_pointer_unit_test.sv
// self-checking bench for the dual data pointer unit
`timescale 1ns/1ps
module dual_data_pointer_unit_test;
  import active_address_pointer_pkg::*;
  // ************************
  // signals and expected state
  // ************************
  logic              aclk    = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr  = '0;
  logic [ADDR_W-1:0] araddr  = '0;
  logic [31:0]       wdata   = '0;
  logic [3:0]        wstrb   = 4'hF;
  logic              awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [PTR_W-1:0]  active_address_pointer;
  move_req_t         core_move;
  logic [7:0]        ctrl_e;
  logic [23:0]       main_e, shad_e;
  logic [23:0]       load_val [2] = '{24'h000001, 24'h00FFFF};
  int                n_errors = 0, check_count = 0, cycles = 0, i, j, k;

  always #4 aclk = ~aclk;

  dual_data_pointer_unit dual_data_pointer_unit_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .core_move(core_move),
    .active_address_pointer(active_address_pointer));
  core_model core_model_i (.aclk(aclk), .core_move(core_move));

  // ************************
  // checking and bus tasks
  // ************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // every channel is judged on the values sampled at the rising edge and released right after it
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= ADDR_W'({idx, 2'b00});
    wdata   <= {24'h0, data};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(32'(bresp), 32'(resp));
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge aclk);
    araddr  <= ADDR_W'({idx, 2'b00});
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, exp);
    chk(32'(rresp), 32'(resp));
  endtask : rd_chk

  function automatic logic [23:0] step(input logic [23:0] p, input logic [1:0] m);
    case (m)
      2'h1: step = p + 24'h1;
      2'h2: step = p - 24'h1;
      2'h3: step = p ^ 24'h1;
      default: step = p;
    endcase
  endfunction : step

  // expected effect: adjust the pointer active during the move, then swap
  task automatic do_move(input move_kind_t kind, input int n);
    core_model_i.move(kind, n);
    repeat (n) begin
      if (kind == MOVE_ACTIVE_ADDRESS_POINTER_MOVX || kind == MOVE_ACTIVE_ADDRESS_POINTER_MOVC) begin
        if (ctrl_e[SEL_BIT]) shad_e = step(shad_e, ctrl_e[SHADOW_MODE_LSB+:2]);
        else main_e = step(main_e, ctrl_e[MAIN_MODE_LSB+:2]);
        if (ctrl_e[SWAP_BIT]) ctrl_e[SEL_BIT] = ~ctrl_e[SEL_BIT];
      end
    end
    @(negedge aclk);
  endtask : do_move

  task automatic check_state();
    logic [23:0] act;
    act = ctrl_e[SEL_BIT] ? shad_e : main_e;
    chk(32'(active_address_pointer), 32'(act));
    rd_chk(IDX_CONTROL, 32'(ctrl_e), RESP_OKAY);
    rd_chk(IDX_LOW, 32'(act[7:0]), RESP_OKAY);
    rd_chk(IDX_HIGH, 32'(act[15:8]), RESP_OKAY);
    rd_chk(IDX_PAGE, 32'(act[23:16]), RESP_OKAY);
  endtask : check_state

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // ************************
  // timeout and test sequence
  // ************************
  // the full sweep needs about 8050 cycles; the ceiling leaves ample margin
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    ctrl_e = CTRL_RESET;
    main_e = PTR_RESET;
    shad_e = PTR_RESET;
    check_state();
    rd_chk(8'hB3, 32'h0, RESP_SLVERR);
    axi_wr(8'hB3, 8'hA5, RESP_SLVERR);
    // a write without lane 0 is answered but must leave the select bit alone
    wstrb <= 4'hE;
    axi_wr(IDX_CONTROL, 8'h01, RESP_OKAY);
    wstrb <= 4'hF;
    check_state();
    $display("test reset_and_map done");
    // load each pointer through the byte registers while it is active
    for (i = 0; i < 2; i++) begin
      axi_wr(IDX_CONTROL, 8'(i), RESP_OKAY);
      ctrl_e = 8'(i);
      for (j = 0; j < 3; j++) axi_wr(IDX_LOW + 8'(j), load_val[i][8*j+:8], RESP_OKAY);
      if (i == 0) main_e = load_val[0];
      else shad_e = load_val[1];
      check_state();
    end
    $display("test pointer_bytes done");
    // every control value with the unused bits set, every move kind, single and back to back
    for (i = 0; i < 128; i++) begin
      axi_wr(IDX_CONTROL, 8'(i) | 8'h82, RESP_OKAY);
      ctrl_e = 8'(i) & CTRL_MASK;
      for (k = 0; k < 4; k++) begin
        do_move(move_kind_t'(k), 1 + i % 2);
        check_state();
      end
    end
    $display("test mode_sweep done");
    complete_run();
  end
endmodule : dual_data_pointer_unit_test
